// ---- atc_map.vh ----
// Constants for the acquisition trigger control block
// Functional notes
// - One scan pulse per conversion in scanning modes
// - Scan pulse rising edge: sampled signal released
// - Strobe write: active-low pulse, at least 500 ns
// - Post-trigger: trigger falling edge starts sequence
// - Pre-trigger: first edge pre, second edge post
// - Gate low inhibits conversions, high permits them
// - Each convert falling edge performs one conversion; edges inside the busy window are dropped and set overrun instead
// - Ignore convert edges outside sequence or gated
// - Paired: 32 channels of 64 lines; single-ended: 64 of 64
// - Reference node grounded only in paired/grounded
// - Two 4-bit ports, direction programmable, input default
// - Timed update edge loads posted values, optional interrupt
`ifndef ATC_MAP_VH
`define ATC_MAP_VH

`define ATC_CLOCK_PERIOD_NS    8
`define ATC_STROBE_LOW_NS      500
`define ATC_STROBE_LOW_CYCLES  ((`ATC_STROBE_LOW_NS + `ATC_CLOCK_PERIOD_NS - 1) / `ATC_CLOCK_PERIOD_NS)
`define ATC_SCAN_HIGH_CYCLES   4
`define ATC_CONV_BUSY_CYCLES   16
`define ATC_TIMER_WIDTH        8

`define ATC_MODE_PAIRED        2'h0
`define ATC_MODE_GROUNDED      2'h1
`define ATC_MODE_FLOATING      2'h2
`define ATC_PAIRED_CHANNELS    7'h20
`define ATC_SINGLE_CHANNELS    7'h40
`define ATC_PAIR_OFFSET        6'h08

`define ATC_PORT_WIDTH         4
`define ATC_DAC_WIDTH          12
`define ATC_COUNT_WIDTH        16
`define ATC_DIO_DIR_RESET      2'h0
`define ATC_DIO_DATA_RESET     8'h00
`define ATC_DAC_RESET          12'h000

`endif

// ---- atc_edge_sync.v ----
// Two-stage synchroniser with falling-edge detector for an active-low pin
`timescale 1ns/10ps
module atc_edge_sync (
	input	wire	clock,
	input	wire	rst_n,
	input	wire	clock_enable,
	input	wire	pin_n,
	output	reg	level,
	output	reg	fall
);
	reg	meta;
	reg	prior;

	// Pins idle high, so the chain resets high to avoid a false edge
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b1;
			level <= 1'b1;
			prior <= 1'b1;
			fall <= 1'b0;
		end else if (clock_enable) begin
			meta <= pin_n;
			level <= meta;
			prior <= level;
			fall <= prior & ~level;
		end
	end
endmodule // atc_edge_sync

// ---- atc_pulse_timer.v ----
// Retriggerable fixed-length pulse generator with selectable idle level
`timescale 1ns/10ps
module atc_pulse_timer #(
	parameter	CYCLES = 63,
	parameter	WIDTH = 8,
	parameter [0:0]	IDLE_LEVEL = 1'b0
) (
	input	wire	clock,
	input	wire	rst_n,
	input	wire	clock_enable,
	input	wire	start,
	output	reg	pulse_out
);
	localparam integer	LAST_INT = CYCLES - 1;
	localparam [WIDTH-1:0]	LAST = LAST_INT[WIDTH-1:0];
	reg [WIDTH-1:0]	count;

	// Active for exactly CYCLES clocks starting at the edge that takes start
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= {WIDTH{1'b0}};
			pulse_out <= IDLE_LEVEL;
		end else if (clock_enable) begin
			if (start) begin
				count <= LAST;
				pulse_out <= ~IDLE_LEVEL;
			end else if (count != {WIDTH{1'b0}}) begin
				count <= count - 1'b1;
			end else begin
				pulse_out <= IDLE_LEVEL;
			end
		end
	end
endmodule // atc_pulse_timer

// ---- atc_trigger_control.v ----
// Acquisition trigger, gate, convert, strobe, input mode and digital port control
`timescale 1ns/10ps
`include "atc_map.vh"
module atc_trigger_control #(
	parameter	STROBE_CYCLES = `ATC_STROBE_LOW_CYCLES,
	parameter	SCAN_HIGH_CYCLES = `ATC_SCAN_HIGH_CYCLES,
	parameter	CONV_BUSY_CYCLES = `ATC_CONV_BUSY_CYCLES,
	parameter	TIMER_WIDTH = `ATC_TIMER_WIDTH,
	parameter	COUNT_WIDTH = `ATC_COUNT_WIDTH,
	parameter	PORT_WIDTH = `ATC_PORT_WIDTH,
	parameter	DAC_WIDTH = `ATC_DAC_WIDTH
) (
	input	wire	clock,
	input	wire	rst_n,
	input	wire	clock_enable,
	input	wire	acquisition_trigger_in_n,
	input	wire	conversion_gate_in_n,
	input	wire	convert_request_in_n,
	input	wire	timed_update_trigger_in_n,
	input	wire	sequence_arm,
	input	wire	sequence_cancel,
	input	wire	pretrigger_enable,
	input	wire	scan_mode_enable,
	input	wire [COUNT_WIDTH-1:0]	post_sample_count,
	input	wire	strobe_write,
	input	wire [1:0]	input_mode,
	input	wire [5:0]	channel_select,
	input	wire	reference_ground_enable,
	input	wire	dio_write,
	input	wire [1:0]	dio_direction,
	input	wire [2*PORT_WIDTH-1:0]	dio_data,
	input	wire [PORT_WIDTH-1:0]	port_a_lines_in,
	input	wire [PORT_WIDTH-1:0]	port_b_lines_in,
	input	wire	timed_update_select,
	input	wire	posted_update_mode,
	input	wire	timed_irq_enable,
	input	wire	timed_irq_clear,
	input	wire	dac_write,
	input	wire	dac_select,
	input	wire [DAC_WIDTH-1:0]	dac_data,
	input	wire	overrun_clear,
	output	wire	per_conversion_pulse_out,
	output	wire	software_pulse_out_n,
	output	reg	adc_convert_start,
	output	reg	sequence_active,
	output	reg	pretrigger_phase,
	output	reg	sequence_done,
	output	reg	conversion_overrun,
	output	reg [5:0]	mux_positive_line,
	output	reg [5:0]	mux_negative_line,
	output	reg	mux_negative_used,
	output	reg	channel_in_range,
	output	reg	input_reference_ground,
	output	reg [PORT_WIDTH-1:0]	port_a_lines_out,
	output	reg [PORT_WIDTH-1:0]	port_a_lines_oe,
	output	reg [PORT_WIDTH-1:0]	port_b_lines_out,
	output	reg [PORT_WIDTH-1:0]	port_b_lines_oe,
	output	reg [2*PORT_WIDTH-1:0]	port_lines_read,
	output	reg [DAC_WIDTH-1:0]	dac0_value,
	output	reg [DAC_WIDTH-1:0]	dac1_value,
	output	reg	dac_update_strobe,
	output	reg	timed_irq
);
	localparam [3:0]	S_IDLE = 4'b0001;
	localparam [3:0]	S_WAIT = 4'b0010;
	localparam [3:0]	S_PRE = 4'b0100;
	localparam [3:0]	S_POST = 4'b1000;
	localparam [2*PORT_WIDTH-1:0]	DIO_DATA_INIT = `ATC_DIO_DATA_RESET;
	localparam [1:0]	DIO_DIR_INIT = `ATC_DIO_DIR_RESET;

	wire	trigger_fall;
	wire	gate_level;
	wire	convert_fall;
	wire	update_fall;
	wire	conv_busy;

	reg [3:0]	state;
	reg [3:0]	next_state;
	reg [COUNT_WIDTH-1:0]	post_target;
	reg [COUNT_WIDTH-1:0]	post_taken;
	reg [COUNT_WIDTH-1:0]	next_post_taken;
	reg	next_done;
	reg [DAC_WIDTH-1:0]	dac0_posted;
	reg [DAC_WIDTH-1:0]	dac1_posted;

	wire	in_sequence;
	wire	convert_accept;
	wire	convert_collide;
	wire	post_last;
	wire	update_event;
	wire [COUNT_WIDTH-1:0]	post_taken_inc;

	// Pin conditioning
	atc_edge_sync u_trigger_sync (
		.clock	(clock),
		.rst_n	(rst_n),
		.clock_enable	(clock_enable),
		.pin_n	(acquisition_trigger_in_n),
		.level	(),
		.fall	(trigger_fall)
	);
	atc_edge_sync u_gate_sync (
		.clock	(clock),
		.rst_n	(rst_n),
		.clock_enable	(clock_enable),
		.pin_n	(conversion_gate_in_n),
		.level	(gate_level),
		.fall	()
	);
	atc_edge_sync u_convert_sync (
		.clock	(clock),
		.rst_n	(rst_n),
		.clock_enable	(clock_enable),
		.pin_n	(convert_request_in_n),
		.level	(),
		.fall	(convert_fall)
	);
	atc_edge_sync u_update_sync (
		.clock	(clock),
		.rst_n	(rst_n),
		.clock_enable	(clock_enable),
		.pin_n	(timed_update_trigger_in_n),
		.level	(),
		.fall	(update_fall)
	);

	// Conversion acceptance
	assign in_sequence = (state == S_PRE) || (state == S_POST);
	// The convert edge passes one register more than the gate level, so the gate sample is one cycle newer
	assign convert_accept = convert_fall & in_sequence & gate_level & ~conv_busy;
	assign convert_collide = convert_fall & in_sequence & gate_level & conv_busy;
	assign post_taken_inc = post_taken + 1'b1;
	assign post_last = (state == S_POST) && convert_accept && (post_taken_inc >= post_target);

	// Busy window keeps scan pulses apart; SCAN_HIGH_CYCLES must stay below it
	atc_pulse_timer #(
		.CYCLES	(CONV_BUSY_CYCLES),
		.WIDTH	(TIMER_WIDTH),
		.IDLE_LEVEL	(1'b0)
	) u_busy_timer (
		.clock	(clock),
		.rst_n	(rst_n),
		.clock_enable	(clock_enable),
		.start	(convert_accept),
		.pulse_out	(conv_busy)
	);
	// Hold is taken at convert start, so the rising edge releases the source
	atc_pulse_timer #(
		.CYCLES	(SCAN_HIGH_CYCLES),
		.WIDTH	(TIMER_WIDTH),
		.IDLE_LEVEL	(1'b0)
	) u_scan_timer (
		.clock	(clock),
		.rst_n	(rst_n),
		.clock_enable	(clock_enable),
		.start	(convert_accept & scan_mode_enable),
		.pulse_out	(per_conversion_pulse_out)
	);
	// A write during a pulse restarts it, so the low time never falls short
	atc_pulse_timer #(
		.CYCLES	(STROBE_CYCLES),
		.WIDTH	(TIMER_WIDTH),
		.IDLE_LEVEL	(1'b1)
	) u_strobe_timer (
		.clock	(clock),
		.rst_n	(rst_n),
		.clock_enable	(clock_enable),
		.start	(strobe_write),
		.pulse_out	(software_pulse_out_n)
	);

	// Acquisition sequencer
	always @* begin
		next_state = state;
		next_post_taken = post_taken;
		next_done = 1'b0;
		case (state)
			S_IDLE: begin
				next_post_taken = {COUNT_WIDTH{1'b0}};
				if (sequence_arm)
					next_state = S_WAIT;
			end
			S_WAIT: begin
				if (trigger_fall) begin
					if (pretrigger_enable)
						next_state = S_PRE;
					else
						next_state = S_POST;
				end
			end
			S_PRE: begin
				if (trigger_fall)
					next_state = S_POST;
			end
			S_POST: begin
				if (convert_accept)
					next_post_taken = post_taken_inc;
				if (post_last) begin
					next_state = S_IDLE;
					next_done = 1'b1;
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
		if (sequence_cancel) begin
			next_state = S_IDLE;
			next_done = 1'b0;
		end
	end
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			post_taken <= {COUNT_WIDTH{1'b0}};
			post_target <= {COUNT_WIDTH{1'b0}};
			sequence_active <= 1'b0;
			pretrigger_phase <= 1'b0;
			sequence_done <= 1'b0;
			adc_convert_start <= 1'b0;
		end else if (clock_enable) begin
			state <= next_state;
			post_taken <= next_post_taken;
			if ((state == S_IDLE) && sequence_arm)
				post_target <= post_sample_count;
			sequence_active <= (next_state != S_IDLE);
			pretrigger_phase <= (next_state == S_PRE);
			sequence_done <= next_done;
			adc_convert_start <= convert_accept;
		end
	end
	// Overrun: an edge lost to a busy converter, set wins over clear
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			conversion_overrun <= 1'b0;
		end else if (clock_enable) begin
			if (convert_collide)
				conversion_overrun <= 1'b1;
			else if (overrun_clear)
				conversion_overrun <= 1'b0;
		end
	end
	// Input mode channel mapping
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mux_positive_line <= 6'h00;
			mux_negative_line <= 6'h00;
			mux_negative_used <= 1'b0;
			channel_in_range <= 1'b0;
			input_reference_ground <= 1'b0;
		end else if (clock_enable) begin
			case (input_mode)
				`ATC_MODE_PAIRED: begin
					// Each pair uses pin n and pin n plus eight within its bank
					mux_positive_line <= {channel_select[4:3], 1'b0, channel_select[2:0]};
					mux_negative_line <= {channel_select[4:3], 1'b0, channel_select[2:0]} |
						`ATC_PAIR_OFFSET;
					mux_negative_used <= 1'b1;
					channel_in_range <= ({1'b0, channel_select} < `ATC_PAIRED_CHANNELS);
				end
				`ATC_MODE_GROUNDED, `ATC_MODE_FLOATING: begin
					mux_positive_line <= channel_select;
					mux_negative_line <= 6'h00;
					mux_negative_used <= 1'b0;
					channel_in_range <= ({1'b0, channel_select} < `ATC_SINGLE_CHANNELS);
				end
				default: begin
					mux_positive_line <= 6'h00;
					mux_negative_line <= 6'h00;
					mux_negative_used <= 1'b0;
					channel_in_range <= 1'b0;
				end
			endcase
			// Floating mode needs the node as its reference, so never ground it there
			input_reference_ground <= reference_ground_enable &
				((input_mode == `ATC_MODE_PAIRED) || (input_mode == `ATC_MODE_GROUNDED));
		end
	end

	// General-purpose digital ports
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			port_a_lines_out <= DIO_DATA_INIT[PORT_WIDTH-1:0];
			port_b_lines_out <= DIO_DATA_INIT[2*PORT_WIDTH-1:PORT_WIDTH];
			port_a_lines_oe <= {PORT_WIDTH{DIO_DIR_INIT[0]}};
			port_b_lines_oe <= {PORT_WIDTH{DIO_DIR_INIT[1]}};
			port_lines_read <= {2*PORT_WIDTH{1'b0}};
		end else if (clock_enable) begin
			if (dio_write) begin
				port_a_lines_out <= dio_data[PORT_WIDTH-1:0];
				port_b_lines_out <= dio_data[2*PORT_WIDTH-1:PORT_WIDTH];
				port_a_lines_oe <= {PORT_WIDTH{dio_direction[0]}};
				port_b_lines_oe <= {PORT_WIDTH{dio_direction[1]}};
			end
			port_lines_read <= {port_b_lines_in, port_a_lines_in};
		end
	end

	// Posted output converter update
	assign update_event = update_fall & timed_update_select & posted_update_mode;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dac0_posted <= `ATC_DAC_RESET;
			dac1_posted <= `ATC_DAC_RESET;
			dac0_value <= `ATC_DAC_RESET;
			dac1_value <= `ATC_DAC_RESET;
			dac_update_strobe <= 1'b0;
		end else if (clock_enable) begin
			if (dac_write && !dac_select)
				dac0_posted <= dac_data;
			if (dac_write && dac_select)
				dac1_posted <= dac_data;
			// A write in the update cycle lands in the posted copy for the next edge
			if (update_event) begin
				dac0_value <= dac0_posted;
				dac1_value <= dac1_posted;
			end else if (dac_write && !posted_update_mode) begin
				if (dac_select)
					dac1_value <= dac_data;
				else
					dac0_value <= dac_data;
			end
			dac_update_strobe <= update_event;
		end
	end

	// Timed interrupt flag, set wins over clear
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timed_irq <= 1'b0;
		end else if (clock_enable) begin
			if (update_event && timed_irq_enable)
				timed_irq <= 1'b1;
			else if (timed_irq_clear)
				timed_irq <= 1'b0;
		end
	end
endmodule // atc_trigger_control

// ---- atc_trigger_control_sva.sv ----
// Port-level checks on the trigger control block
`timescale 1ns/10ps
module atc_check #(
	parameter	STROBE_CYCLES = 63
) (
	input	wire		clock,
	input	wire		rst_n,
	input	wire		conversion_gate_in_n,
	input	wire		sequence_cancel,
	input	wire		strobe_write,
	input	wire [1:0]	input_mode,
	input	wire		reference_ground_enable,
	input	wire		dio_write,
	input	wire [1:0]	dio_direction,
	input	wire		scan_mode_enable,
	input	wire		per_conversion_pulse_out,
	input	wire		software_pulse_out_n,
	input	wire		adc_convert_start,
	input	wire		sequence_active,
	input	wire		pretrigger_phase,
	input	wire		sequence_done,
	input	wire [5:0]	mux_positive_line,
	input	wire [5:0]	mux_negative_line,
	input	wire		mux_negative_used,
	input	wire		input_reference_ground,
	input	wire [3:0]	port_a_lines_oe
);
	reg	[7:0]	low_count;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Saturates so a stuck strobe cannot wrap back into range
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			low_count <= 8'h00;
		else if (software_pulse_out_n)
			low_count <= 8'h00;
		else if (low_count != 8'hFF)
			low_count <= low_count + 8'h01;
	end
	scan_per_conv_a: assert property (adc_convert_start && $past(scan_mode_enable) |-> per_conversion_pulse_out)
		else $error("scan pulse missing at conversion");
	scan_width_a: assert property ($rose(per_conversion_pulse_out) |-> adc_convert_start ##0 per_conversion_pulse_out[*4] ##1 !per_conversion_pulse_out)
		else $error("scan pulse wrong width");
	strobe_start_a: assert property (strobe_write |=> !software_pulse_out_n)
		else $error("strobe did not go low");
	strobe_width_a: assert property ($rose(software_pulse_out_n) |-> low_count >= STROBE_CYCLES)
		else $error("strobe low too short");
	gate_inhibit_a: assert property (!conversion_gate_in_n[*6] |-> !adc_convert_start)
		else $error("conversion while gated off");
	idle_no_conv_a: assert property (!$past(sequence_active) |-> !adc_convert_start)
		else $error("conversion outside sequence");
	conv_spacing_a: assert property (adc_convert_start |=> !adc_convert_start[*8])
		else $error("conversions too close");
	done_with_conv_a: assert property (sequence_done |-> adc_convert_start && !pretrigger_phase)
		else $error("done without conversion");
	cancel_idle_a: assert property (sequence_cancel |=> ##1 !sequence_active && !pretrigger_phase)
		else $error("cancel left sequence running");
	pre_in_seq_a: assert property (pretrigger_phase |-> sequence_active)
		else $error("pretrigger phase while idle");
	paired_neg_a: assert property ($past(rst_n) && $past(input_mode) == 2'h0 |-> mux_negative_used && mux_negative_line == (mux_positive_line | 6'h08))
		else $error("paired negative line wrong");
	ref_ground_a: assert property ($past(rst_n) |-> input_reference_ground == ($past(reference_ground_enable) && $past(input_mode) < 2'h2))
		else $error("reference ground wrong");
	port_dir_a: assert property (dio_write |=> port_a_lines_oe == {4{$past(dio_direction[0])}})
		else $error("port direction wrong");
endmodule // atc_check

bind atc_trigger_control atc_check #(.STROBE_CYCLES(STROBE_CYCLES)) chk (.*);

// ---- atc_pin_driver.sv ----
// Test equipment model on the trigger, gate, convert and update pins
`timescale 1ns/10ps
module atc_pin_driver (
	input	wire	clock,
	output	reg	acquisition_trigger_in_n,
	output	reg	conversion_gate_in_n,
	output	reg	convert_request_in_n,
	output	reg	timed_update_trigger_in_n
);
	initial begin
		acquisition_trigger_in_n = 1'b1;
		conversion_gate_in_n = 1'b1;
		convert_request_in_n = 1'b1;
		timed_update_trigger_in_n = 1'b1;
	end
	// Held low four cycles so the synchroniser cannot miss the edge
	task strike(input [2:0] sel);
		@(posedge clock);
		acquisition_trigger_in_n <= ~sel[2];
		convert_request_in_n <= ~sel[1];
		timed_update_trigger_in_n <= ~sel[0];
		repeat (4) @(posedge clock);
		acquisition_trigger_in_n <= 1'b1;
		convert_request_in_n <= 1'b1;
		timed_update_trigger_in_n <= 1'b1;
		repeat (4) @(posedge clock);
	endtask
	task gate(input lvl);
		@(posedge clock);
		conversion_gate_in_n <= lvl;
	endtask
endmodule // atc_pin_driver

// ---- atc_trigger_control_tb.sv ----
// Self-checking bench for the trigger control block
`timescale 1ns/10ps
module atc_trigger_control_tb;
	logic clock = 0, rst_n = 0, clock_enable = 1, sequence_arm = 0, sequence_cancel = 0;
	logic pretrigger_enable = 0, scan_mode_enable = 1, strobe_write = 0, dio_write = 0;
	logic reference_ground_enable = 0, timed_update_select = 0, posted_update_mode = 0;
	logic timed_irq_enable = 0, timed_irq_clear = 0, dac_write = 0, dac_select = 0;
	logic overrun_clear = 0, scan_q = 0;
	logic [15:0] post_sample_count = 16'h0001;
	logic [1:0] input_mode = 2'h0, dio_direction = 2'h0;
	logic [5:0] channel_select = 6'h00, mux_positive_line, mux_negative_line;
	logic [7:0] dio_data = 8'h00, port_lines_read;
	logic [3:0] port_a_lines_in = 4'h0, port_b_lines_in = 4'h9;
	logic [3:0] port_a_lines_out, port_a_lines_oe, port_b_lines_out, port_b_lines_oe;
	logic [11:0] dac_data = 12'h000, dac0_value, dac1_value;
	logic per_conversion_pulse_out, software_pulse_out_n, adc_convert_start;
	logic sequence_active, pretrigger_phase, sequence_done, conversion_overrun;
	logic mux_negative_used, channel_in_range, input_reference_ground;
	logic dac_update_strobe, timed_irq;
	wire acquisition_trigger_in_n, conversion_gate_in_n;
	wire convert_request_in_n, timed_update_trigger_in_n;
	int n_errors = 0, checks_done = 0, n_conv = 0, n_scan = 0, cycles = 0, i;
	int n_done = 0, n_upd = 0;
	atc_trigger_control uut (.*);
	atc_pin_driver pins (.*);
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		scan_q <= per_conversion_pulse_out;
		if (adc_convert_start === 1'b1)
			n_conv <= n_conv + 1;
		if (per_conversion_pulse_out === 1'b1 && scan_q !== 1'b1)
			n_scan <= n_scan + 1;
		if (sequence_done === 1'b1)
			n_done <= n_done + 1;
		if (dac_update_strobe === 1'b1)
			n_upd <= n_upd + 1;
		if (cycles == 5000) begin
			n_errors++;
			conclude();
		end
	end
	task tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Spaced past the busy window so none is refused as an overrun
	task conv(input int n);
		repeat (n) begin
			pins.strike(3'h2);
			tick(12);
		end
	endtask
	task arm;
		sequence_arm <= 1'b1;
		tick(1);
		sequence_arm <= 1'b0;
		tick(2);
		pins.strike(3'h4);
		tick(2);
	endtask
	task cancel;
		sequence_cancel <= 1'b1;
		tick(1);
		sequence_cancel <= 1'b0;
		tick(3);
	endtask
	initial begin
		tick(16);
		rst_n <= 1'b1;
		tick(2);
		chk("strobe idle", software_pulse_out_n, 12'h001);
		chk("port a oe", port_a_lines_oe, 12'h000);
		strobe_write <= 1'b1;
		tick(1);
		strobe_write <= 1'b0;
		for (i = 0; i < 9 && software_pulse_out_n !== 1'b0; i++)
			tick(1);
		for (i = 0; i < 200 && software_pulse_out_n === 1'b0; i++)
			tick(1);
		chk("strobe low", i, 12'h03F);
		conv(1);
		chk("idle conv", n_conv, 12'h000);
		post_sample_count <= 16'h0003;
		arm();
		chk("active", sequence_active, 12'h001);
		conv(3);
		chk("conv count", n_conv, 12'h003);
		chk("scan count", n_scan, 12'h003);
		chk("done count", n_done, 12'h001);
		chk("seq end", sequence_active, 12'h000);
		arm();
		pins.gate(1'b0);
		tick(6);
		conv(1);
		chk("gated conv", n_conv, 12'h003);
		pins.gate(1'b1);
		tick(6);
		conv(1);
		chk("open conv", n_conv, 12'h004);
		cancel();
		chk("cancelled", sequence_active, 12'h000);
		conv(1);
		chk("after cancel", n_conv, 12'h004);
		pretrigger_enable <= 1'b1;
		arm();
		chk("pre phase", pretrigger_phase, 12'h001);
		scan_mode_enable <= 1'b0;
		conv(1);
		chk("pre conv", n_conv, 12'h005);
		chk("no scan", n_scan, 12'h004);
		scan_mode_enable <= 1'b1;
		pins.strike(3'h2);
		pins.strike(3'h2);
		tick(12);
		chk("overrun conv", n_conv, 12'h006);
		chk("overrun", conversion_overrun, 12'h001);
		overrun_clear <= 1'b1;
		tick(1);
		overrun_clear <= 1'b0;
		tick(1);
		chk("overrun clear", conversion_overrun, 12'h000);
		pins.strike(3'h4);
		tick(2);
		chk("post phase", {pretrigger_phase, sequence_active}, 12'h001);
		cancel();
		arm();
		chk("pre again", pretrigger_phase, 12'h001);
		cancel();
		reference_ground_enable <= 1'b1;
		channel_select <= 6'h28;
		for (i = 0; i < 3; i++) begin
			input_mode <= i[1:0];
			tick(3);
			chk("in range", channel_in_range, {11'h000, i != 0});
			chk("ref ground", input_reference_ground, {11'h000, i != 2});
			chk("pos line", mux_positive_line, (i == 0) ? 12'h010 : 12'h028);
			chk("neg line", mux_negative_line, (i == 0) ? 12'h018 : 12'h000);
			chk("neg used", mux_negative_used, {11'h000, i == 0});
		end
		dio_direction <= 2'h1;
		dio_data <= 8'hA5;
		dio_write <= 1'b1;
		tick(1);
		dio_write <= 1'b0;
		port_a_lines_in <= 4'h3;
		tick(3);
		chk("port a", {port_a_lines_oe, port_a_lines_out}, 12'h0F5);
		chk("port b oe", port_b_lines_oe, 12'h000);
		chk("port b", {port_b_lines_oe, port_b_lines_out}, 12'h00A);
		chk("port read", port_lines_read, 12'h093);
		posted_update_mode <= 1'b1;
		timed_update_select <= 1'b1;
		timed_irq_enable <= 1'b1;
		dac_data <= 12'h5A3;
		dac_write <= 1'b1;
		tick(1);
		dac_write <= 1'b0;
		tick(2);
		chk("dac posted", dac0_value, 12'h000);
		dac_select <= 1'b1;
		dac_data <= 12'h3C6;
		dac_write <= 1'b1;
		tick(1);
		dac_write <= 1'b0;
		tick(1);
		chk("dac1 posted", dac1_value, 12'h000);
		pins.strike(3'h1);
		chk("dac updated", dac0_value, 12'h5A3);
		chk("dac1 updated", dac1_value, 12'h3C6);
		chk("update strobe", n_upd, 12'h001);
		chk("timed irq", timed_irq, 12'h001);
		timed_irq_clear <= 1'b1;
		tick(1);
		timed_irq_clear <= 1'b0;
		tick(1);
		chk("irq cleared", timed_irq, 12'h000);
		conclude();
	end
endmodule // atc_trigger_control_tb
